// file: hw/hpdl_regs.vh
// register offsets, field positions and reset values of the lane mapper
`ifndef HPDL_REGS_VH
`define HPDL_REGS_VH

// ------------------------------------------------------------------
// register offsets (8-bit register port)
// ------------------------------------------------------------------
`define HPDL_PANEL_CTRL_ADDR   8'h14
`define HPDL_STATUS_ADDR       8'h15

// ------------------------------------------------------------------
// panel control register fields
// ------------------------------------------------------------------
`define HPDL_PCTRL_BPP18_BIT   0
`define HPDL_PCTRL_REV_BIT     7
`define HPDL_PCTRL_MASK        8'h81
`define HPDL_PCTRL_RESET       8'h01

// ------------------------------------------------------------------
// status register fields
// ------------------------------------------------------------------
`define HPDL_STAT_ORDER_BIT    0
`define HPDL_STAT_WIDTH_BIT    1
`define HPDL_STAT_RESET        8'h00

// ------------------------------------------------------------------
// widths and fixed values
// ------------------------------------------------------------------
`define HPDL_HOST_W            16
`define HPDL_BYTE_W            8
`define HPDL_LANE_W            18
`define HPDL_COMP_W            6
`define HPDL_ZERO_BYTE         8'h00

`endif

// file: hw/hpdl_lane_mapper.v
// host data lane and panel data lane mapper of the display controller
`timescale 1ns/1ps
`include "hpdl_regs.vh"

// Overview of operation
// - width strap low: 8-bit host bus, every register access a single byte
// - width strap high: register accesses stay 8-bit, core upper byte zeroed; lane-order strap low puts the byte on pins 15-8
// - width strap high: memory data port accesses use all 16 host bits
// - lane-order strap high: each host pin carries the bit of same index
// - lane-order strap low: bit order reversed across the active host width
// - straps may change any time; current levels always steer the mapping
// - panel control bit 7 reverses all 18 panel lanes, lane 17 gets lane 0
// - 18bpp normal: lanes 0-5 blue, 6-11 green, 12-17 red
// - 16bpp normal: blue 0-4 on lanes 1-5, B4 on lane 0; red alike from 12
module hpdl_lane_mapper #(
   parameter HOST_W = `HPDL_HOST_W,
   parameter LANE_W = `HPDL_LANE_W
) (
   input  wire                clock_i,
   input  wire                rst_n_i,
   input  wire                host_lane_order_strap_i,
   input  wire                host_width_strap_i,
   input  wire [7:0]          reg_addr_i,
   input  wire [7:0]          reg_wdata_i,
   input  wire                reg_wr_i,
   input  wire                reg_rd_i,
   output reg  [7:0]          reg_rdata_o,
   input  wire [HOST_W-1:0]   host_data_pin_i,
   input  wire                host_mem_port_i,
   input  wire                host_read_i,
   input  wire [HOST_W-1:0]   core_rd_data_i,
   output reg  [HOST_W-1:0]   core_wr_data_o,
   output reg  [HOST_W-1:0]   host_data_pin_o,
   output reg  [HOST_W-1:0]   host_data_pin_oe_o,
   input  wire [5:0]          red_i,
   input  wire [5:0]          green_i,
   input  wire [5:0]          blue_i,
   output reg  [LANE_W-1:0]   panel_lane_o
);

   // ---------------------------------------------------------------
   // lane functions
   // ---------------------------------------------------------------

   // reverse across the active host width; narrow mode keeps upper zero
   function [15:0] host_swap;
      input [15:0] data;
      input        wide;
      input        natural;
      integer      k;
      begin
         host_swap = 16'h0000;
         for (k = 0; k < 16; k = k + 1) begin
            if (natural) begin
               host_swap[k] = data[k];
            end else if (wide) begin
               host_swap[k] = data[15-k];
            end else if (k < 8) begin
               host_swap[k] = data[7-k];
            end
         end
         if (!wide) begin
            host_swap[15:8] = `HPDL_ZERO_BYTE;
         end
      end
   endfunction

   // place pixel components on the lanes in natural order
   function [17:0] pixel_lanes;
      input [5:0] red;
      input [5:0] green;
      input [5:0] blue;
      input       bpp18;
      begin
         if (bpp18) begin
            pixel_lanes = {red, green, blue};
         end else begin
            pixel_lanes = {red[4:0], red[4], green,
                           blue[4:0], blue[4]};
         end
      end
   endfunction

   // full lane reversal of the panel bus
   function [17:0] lane_reverse;
      input [17:0] data;
      integer      k;
      begin
         lane_reverse = 18'h00000;
         for (k = 0; k < 18; k = k + 1) begin
            lane_reverse[k] = data[17-k];
         end
      end
   endfunction

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   reg  [7:0]        panel_ctrl;
   wire              panel_rev;
   wire              panel_bpp18;
   wire              wide_mode;
   wire              natural_order;
   wire              full_word;
   wire [7:0]        status_word;

   // straps are used live, never latched, so a change applies at once
   assign wide_mode     = host_width_strap_i;
   assign natural_order = host_lane_order_strap_i;
   assign panel_rev     = panel_ctrl[`HPDL_PCTRL_REV_BIT];
   assign panel_bpp18   = panel_ctrl[`HPDL_PCTRL_BPP18_BIT];

   // only the memory data port may use the upper byte
   assign full_word = wide_mode & host_mem_port_i;

   assign status_word = {6'h00, wide_mode, natural_order};

   // ---------------------------------------------------------------
   // register port
   // ---------------------------------------------------------------
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         panel_ctrl <= `HPDL_PCTRL_RESET;
      end else if (reg_wr_i &&
                   reg_addr_i == `HPDL_PANEL_CTRL_ADDR) begin
         panel_ctrl <= reg_wdata_i & `HPDL_PCTRL_MASK;
      end
   end

   // read data stand only in the cycle after the read strobe
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= `HPDL_ZERO_BYTE;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `HPDL_PANEL_CTRL_ADDR: begin
               reg_rdata_o <= panel_ctrl;
            end
            `HPDL_STATUS_ADDR: begin
               reg_rdata_o <= status_word;
            end
            default: begin
               reg_rdata_o <= `HPDL_ZERO_BYTE;
            end
         endcase
      end else begin
         reg_rdata_o <= `HPDL_ZERO_BYTE;
      end
   end

   // ---------------------------------------------------------------
   // host write path (pins to core)
   // ---------------------------------------------------------------
   reg  [15:0] next_core_wr_data;
   reg  [15:0] host_in_mapped;

   always @* begin
      host_in_mapped    = host_swap(host_data_pin_i, wide_mode,
                                    natural_order);
      next_core_wr_data = host_in_mapped;
      if (!full_word) begin
         // register access: upper byte ignored in either width
         next_core_wr_data[15:8] = `HPDL_ZERO_BYTE;
      end
   end

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         core_wr_data_o <= 16'h0000;
      end else begin
         core_wr_data_o <= next_core_wr_data;
      end
   end

   // ---------------------------------------------------------------
   // host read path (core to pins)
   // ---------------------------------------------------------------
   reg  [15:0] next_pin_data;
   reg  [15:0] next_pin_oe;
   reg  [15:0] rd_source;

   always @* begin
      rd_source = core_rd_data_i;
      if (!full_word) begin
         // register reads return one byte; upper half is zero
         rd_source[15:8] = `HPDL_ZERO_BYTE;
      end
      next_pin_data = host_swap(rd_source, wide_mode,
                                natural_order);
      next_pin_oe   = 16'h0000;
      if (host_read_i) begin
         if (wide_mode) begin
            next_pin_oe = 16'hFFFF;
         end else begin
            // upper pins left to the internal pull-downs
            next_pin_oe = 16'h00FF;
         end
      end
   end

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         host_data_pin_o    <= 16'h0000;
         host_data_pin_oe_o <= 16'h0000;
      end else begin
         host_data_pin_o    <= next_pin_data;
         host_data_pin_oe_o <= next_pin_oe;
      end
   end

   // ---------------------------------------------------------------
   // panel lanes
   // ---------------------------------------------------------------
   reg  [17:0] natural_lanes;
   reg  [17:0] next_panel_lane;

   always @* begin
      natural_lanes = pixel_lanes(red_i, green_i, blue_i, panel_bpp18);
      if (panel_rev) begin
         next_panel_lane = lane_reverse(natural_lanes);
      end else begin
         next_panel_lane = natural_lanes;
      end
   end

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         panel_lane_o <= 18'h00000;
      end else begin
         panel_lane_o <= next_panel_lane;
      end
   end

endmodule

// file: verif/hpdl_lane_mapper_checker.sv
// concurrent checks on the lane mapper host side ports
`timescale 1ns/1ps
module hpdl_lane_mapper_checker (
   input wire        clock_i,
   input wire        rst_n_i,
   input wire        host_lane_order_strap_i,
   input wire        host_width_strap_i,
   input wire        reg_rd_i,
   input wire [7:0]  reg_rdata_o,
   input wire [15:0] host_data_pin_i,
   input wire        host_mem_port_i,
   input wire        host_read_i,
   input wire [15:0] core_rd_data_i,
   input wire [15:0] core_wr_data_o,
   input wire [15:0] host_data_pin_o,
   input wire [15:0] host_data_pin_oe_o
);
   wire wide = host_width_strap_i & host_mem_port_i;
   wire nat  = host_lane_order_strap_i;
   wire rdn  = host_read_i & ~host_width_strap_i;
   function automatic [15:0] rv(input [15:0] d);
      for (int k = 0; k < 16; k++) rv[k] = d[15-k];
   endfunction
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
      else $error("read data outside its slot");
   a_upper_ignored: assert property (!wide |=> core_wr_data_o[15:8] == 8'h00)
      else $error("upper byte passed");
   a_wide_natural: assert property (wide && nat |=>
      core_wr_data_o == $past(host_data_pin_i))
      else $error("wide natural write");
   a_wide_reversed: assert property (wide && !nat |=>
      core_wr_data_o == rv($past(host_data_pin_i)))
      else $error("wide reversed write");
   a_narrow_rev: assert property (!host_width_strap_i && !nat |=>
      core_wr_data_o == rv({$past(host_data_pin_i[7:0]), 8'h00}))
      else $error("narrow reversed write");
   a_narrow_oe: assert property (rdn |=> host_data_pin_oe_o == 16'h00FF)
      else $error("narrow enable");
   a_wide_oe: assert property (host_read_i && host_width_strap_i |=>
      host_data_pin_oe_o == 16'hFFFF)
      else $error("wide enable");
   a_idle_oe: assert property (!host_read_i |=> host_data_pin_oe_o == 16'h0000)
      else $error("pins driven outside read");
   a_read_rev: assert property (wide && !nat && host_read_i |=>
      host_data_pin_o == rv($past(core_rd_data_i)))
      else $error("reversed read data");
   a_read_nat: assert property (rdn && nat |=>
      host_data_pin_o == {8'h00, $past(core_rd_data_i[7:0])})
      else $error("narrow natural read");
endmodule
bind hpdl_lane_mapper hpdl_lane_mapper_checker u_chk (.clock_i, .rst_n_i,
   .host_lane_order_strap_i, .host_width_strap_i, .reg_rd_i, .reg_rdata_o,
   .host_data_pin_i, .host_mem_port_i, .host_read_i, .core_rd_data_i,
   .core_wr_data_o, .host_data_pin_o, .host_data_pin_oe_o);

// file: verif/hpdl_host_model.sv
// host processor model resolving the shared host data pins
`timescale 1ns/1ps
module hpdl_host_model (
   input  wire        clock_i,
   input  wire        host_read_i,
   input  wire        host_width_strap_i,
   input  wire [15:0] host_data_i,
   input  wire [15:0] dev_data_i,
   input  wire [15:0] dev_oe_i,
   output reg  [15:0] pins_o
);
   reg [15:0] last = 16'h0000;
   always @(posedge clock_i) last <= pins_o;
   // released low pins show a changing value, upper pins the pull-down
   always @* begin
      for (int k = 0; k < 16; k++)
         if (dev_oe_i[k]) pins_o[k] = dev_data_i[k];
         else if (!host_read_i && (host_width_strap_i || k < 8))
            pins_o[k] = host_data_i[k];
         else pins_o[k] = (k < 8) ? ~last[k] : 1'b0;
   end
endmodule

// file: verif/hpdl_lane_mapper_tb.sv
// self-checking bench of the lane mapper
`timescale 1ns/1ps
module hpdl_lane_mapper_tb;
   logic        clock_i = 1'b0, rst_n_i = 1'b0;
   logic        host_lane_order_strap_i = 1'b1, host_width_strap_i = 1'b1;
   logic [7:0]  reg_addr_i = '0, reg_wdata_i = '0, reg_rdata_o;
   logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic        host_mem_port_i = 1'b0, host_read_i = 1'b0;
   logic [15:0] host_data = '0, core_rd_data_i = '0, host_data_pin_i;
   logic [15:0] core_wr_data_o, host_data_pin_o, host_data_pin_oe_o;
   logic [5:0]  red_i = '0, green_i = '0, blue_i = '0;
   logic [17:0] panel_lane_o;
   int          failures = 0, checks_done = 0, cycles = 0;
   // order width mem read, source data, expected data
   logic [35:0] rows [10] = '{36'hE_A5C3_A5C3, 36'h6_0001_8000,
      36'hC_A5C3_00C3, 36'h0_0001_0080, 36'h8_12F3_00F3, 36'hF_1234_1234,
      36'h7_0001_8000, 36'h1_0001_0080, 36'hD_ABCD_00CD, 36'h9_12AB_00AB};
   hpdl_lane_mapper u_dut (.clock_i, .rst_n_i, .host_lane_order_strap_i,
      .host_width_strap_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .host_data_pin_i, .host_mem_port_i, .host_read_i,
      .core_rd_data_i, .core_wr_data_o, .host_data_pin_o,
      .host_data_pin_oe_o, .red_i, .green_i, .blue_i, .panel_lane_o);
   hpdl_host_model u_host (.clock_i, .host_read_i, .host_width_strap_i,
      .host_data_i(host_data), .dev_data_i(host_data_pin_o),
      .dev_oe_i(host_data_pin_oe_o), .pins_o(host_data_pin_i));
   always #20 clock_i = ~clock_i;
   function automatic [17:0] pan(input [7:0] c, input [5:0] r, g, b);
      logic [17:0] l;
      l = c[0] ? {r, g, b} : {r[4:0], r[4], g, b[4:0], b[4]};
      for (int k = 0; k < 18; k++) pan[k] = c[7] ? l[17-k] : l[k];
   endfunction
   task chk(input logic [17:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input [7:0] a, d);
      @(posedge clock_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
      @(posedge clock_i) reg_wr_i <= 1'b0;
   endtask
   task rd(input [7:0] a, exp);
      @(posedge clock_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
      @(posedge clock_i) reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, exp);
   endtask
   task close_out;
      $display("failures %0d checks %0d", failures, checks_done);
      if (failures == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         close_out;
      end
   end
   initial begin
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rd(8'h14, 8'h01);
      wr(8'h15, 8'h00);
      rd(8'h15, 8'h03);
      rd(8'h33, 8'h00);
      wr(8'h14, 8'hFF);
      rd(8'h14, 8'h81);
      foreach (rows[i]) begin
         @(posedge clock_i);
         {host_lane_order_strap_i, host_width_strap_i, host_mem_port_i,
            host_read_i} <= rows[i][35:32];
         host_data <= rows[i][31:16];
         core_rd_data_i <= rows[i][31:16];
         @(posedge clock_i);
         #1 chk(host_read_i ? host_data_pin_o : core_wr_data_o, rows[i][15:0]);
      end
      rd(8'h15, {6'h00, host_width_strap_i, host_lane_order_strap_i});
      red_i <= 6'h25;
      green_i <= 6'h1A;
      blue_i <= 6'h33;
      for (int j = 0; j < 4; j++) begin
         wr(8'h14, {j[1], 6'h00, j[0]});
         @(posedge clock_i);
         #1 chk(panel_lane_o, pan({j[1], 6'h00, j[0]}, red_i, green_i, blue_i));
      end
      rst_n_i <= 1'b0;
      #1 chk(panel_lane_o, 18'h00000);
      @(posedge clock_i) rst_n_i <= 1'b1;
      rd(8'h14, 8'h01);
      close_out;
   end
endmodule
